//--- tm3_pkg.sv
/*
 package for the timer 3 control block: register offsets, field
 positions, reset values, divider counts and the bus carrier types.
 assumes a byte-wide special-function register bus.
*/
package tm3_pkg;
   // register offsets on the special-function register bus
   localparam logic [7:0] TM3_CTRL_ADDR    = 8'h91;
   localparam logic [7:0] TM3_RELOAD_LO    = 8'h92;
   localparam logic [7:0] TM3_RELOAD_HI    = 8'h93;
   localparam logic [7:0] TM3_COUNT_LO     = 8'h94;
   localparam logic [7:0] TM3_COUNT_HI     = 8'h95;
   // control field positions
   localparam int         TM3_HI_FLAG_BIT  = 7;
   localparam int         TM3_LO_FLAG_BIT  = 6;
   localparam int         TM3_LO_IRQ_BIT   = 5;
   localparam int         TM3_CAPTURE_BIT  = 4;
   localparam int         TM3_SPLIT_BIT    = 3;
   localparam int         TM3_RUN_BIT      = 2;
   // reset values, byte maximum and unmapped read value
   localparam logic [7:0] TM3_CTRL_RESET   = 8'h00;
   localparam logic [7:0] TM3_BYTE_RESET   = 8'h00;
   localparam logic [7:0] TM3_BYTE_MAX     = 8'hff;
   localparam logic [7:0] TM3_UNMAPPED     = 8'h00;
   // divider counts
   localparam int         TM3_CORE_DIV     = 12;
   localparam int         TM3_OSC_DIV      = 8;
   localparam logic [3:0] TM3_CORE_DIV_END = 4'(TM3_CORE_DIV - 1);
   localparam logic [2:0] TM3_OSC_DIV_END  = 3'(TM3_OSC_DIV - 1);

   typedef enum logic [1:0] {
      TM3_XCLK_CORE_DIV = 2'h0,
      TM3_XCLK_OSC      = 2'h1,
      TM3_XCLK_RESERVED = 2'h2,
      TM3_XCLK_COMP     = 2'h3
   } tm3_xclk_t;

   typedef struct packed {
      logic      high_byte_overflow_flag;
      logic      low_byte_overflow_flag;
      logic      low_byte_irq_enable;
      logic      capture_mode_enable;
      logic      split_counter_mode;
      logic      counter_run;
      tm3_xclk_t ext_clock_select;
   } tm3_ctrl_t;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } tm3_sfr_req_t;
endpackage

//--- tm3_timer.sv
/*
 timer 3: control register, 16-bit or split 8-bit auto-reload counter,
 capture mode, external count source selection and interrupt request.
 assumes the per-byte clock selects and the timer interrupt enable come
 from registers elsewhere; comparator and oscillator are raw pins.
*/
// Summary of operation
// - high flag set on upper byte wrap
// - high flag raises irq when enabled
// - flags cleared only by software writes
// - low flag set on lower byte wrap
// - low flag irq when low enable set
// - capture enable selects capture mode
// - split bit picks 16-bit or two 8-bit
// - run gates counter; split: upper only
// - code 00: core/12 clock, comparator trigger
// - code 01: oscillator/8 clock and trigger
// - code 11: comparator clock, oscillator/8 trigger
// - per-byte select: external or core clock
// - external sources synchronised before use
// - 16-bit wrap loads reload pair
// - split: each byte reloads its own byte
// - capture trigger: comparator on code 00, oscillator/8 on any other code
// - capture copies counter, sets high flag
`timescale 1ns/1ps
module tm3_timer
   import tm3_pkg::*;
(
   input  wire logic         clk,
   input  wire logic         reset,
   input  wire tm3_sfr_req_t sfr_req,
   output logic [7:0]        sfr_rdata,
   input  wire logic         upper_byte_clock_select,
   input  wire logic         lower_byte_clock_select,
   input  wire logic         timer_irq_enable,
   input  wire logic         comparator_in,
   input  wire logic         ext_osc_in,
   output logic              timer_irq
);

   tm3_ctrl_t  ctrl_ff;
   logic [7:0] cnt_lo_ff, cnt_hi_ff, rl_lo_ff, rl_hi_ff;
   logic [7:0] rdata_ff;
   logic       irq_ff;
   logic [3:0] div12_ff;
   logic [2:0] osc_div_ff;

   // pin synchronisers: three stages, change counts when 2 and 3 agree
   logic [1:0] pin_in;
   logic [1:0] s1_ff, s2_ff, s3_ff, stable_ff;
   logic [1:0] pin_rise;
   assign pin_in = {ext_osc_in, comparator_in};

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_sync
         always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
               s1_ff[g]     <= 1'b0;
               s2_ff[g]     <= 1'b0;
               s3_ff[g]     <= 1'b0;
               stable_ff[g] <= 1'b0;
            end else begin
               s1_ff[g] <= pin_in[g];
               s2_ff[g] <= s1_ff[g];
               s3_ff[g] <= s2_ff[g];
               if (s2_ff[g] == s3_ff[g]) begin
                  stable_ff[g] <= s3_ff[g];
               end
            end
         end
         assign pin_rise[g] = s2_ff[g] & s3_ff[g] & ~stable_ff[g];
      end
   endgenerate

   logic comp_rise, osc_rise;
   assign comp_rise = pin_rise[0];
   assign osc_rise  = pin_rise[1];

   // core clock divided by twelve
   logic div12_tick;
   assign div12_tick = (div12_ff == TM3_CORE_DIV_END);
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         div12_ff <= 4'h0;
      end else if (div12_tick) begin
         div12_ff <= 4'h0;
      end else begin
         div12_ff <= div12_ff + 4'h1;
      end
   end

   // oscillator divided by eight
   logic osc8_tick;
   assign osc8_tick = osc_rise & (osc_div_ff == TM3_OSC_DIV_END);
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         osc_div_ff <= 3'h0;
      end else if (osc_rise) begin
         osc_div_ff <= osc_div_ff + 3'h1;
      end
   end

   // external clock and capture trigger selection
   logic ext_tick, cap_trig;
   always_comb begin
      case (ctrl_ff.ext_clock_select)
         TM3_XCLK_CORE_DIV: ext_tick = div12_tick;
         TM3_XCLK_OSC:      ext_tick = osc8_tick;
         TM3_XCLK_COMP:     ext_tick = comp_rise;
         TM3_XCLK_RESERVED: ext_tick = 1'b0;
         default:           ext_tick = 1'b0;
      endcase
   end
   // code 00 comparator edge, every other code oscillator/8
   assign cap_trig = ctrl_ff.capture_mode_enable &
      (ctrl_ff.ext_clock_select == TM3_XCLK_CORE_DIV ? comp_rise :
       osc8_tick);

   // per-byte count enable
   logic lo_tick, hi_tick;
   assign lo_tick = lower_byte_clock_select | ext_tick;
   assign hi_tick = upper_byte_clock_select | ext_tick;

   function automatic logic byte_full(input logic [7:0] b);
      byte_full = (b == TM3_BYTE_MAX);
   endfunction

   logic lo_inc, hi_inc, lo_wrap, hi_wrap;
   always_comb begin
      if (ctrl_ff.split_counter_mode) begin
         lo_inc = lo_tick;
         hi_inc = ctrl_ff.counter_run & hi_tick;
      end else begin
         lo_inc = ctrl_ff.counter_run & lo_tick;
         hi_inc = lo_inc & byte_full(cnt_lo_ff);
      end
   end
   assign lo_wrap = lo_inc & byte_full(cnt_lo_ff);
   assign hi_wrap = hi_inc & byte_full(cnt_hi_ff);

   logic wr_ctrl, wr_rl_lo, wr_rl_hi, wr_cnt_lo, wr_cnt_hi;
   assign wr_ctrl   = sfr_req.wr & (sfr_req.addr == TM3_CTRL_ADDR);
   assign wr_rl_lo  = sfr_req.wr & (sfr_req.addr == TM3_RELOAD_LO);
   assign wr_rl_hi  = sfr_req.wr & (sfr_req.addr == TM3_RELOAD_HI);
   assign wr_cnt_lo = sfr_req.wr & (sfr_req.addr == TM3_COUNT_LO);
   assign wr_cnt_hi = sfr_req.wr & (sfr_req.addr == TM3_COUNT_HI);

   // counter bytes: reload on wrap unless capturing
   logic reload_on;
   assign reload_on = ~ctrl_ff.capture_mode_enable;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cnt_lo_ff <= TM3_BYTE_RESET;
      end else if (wr_cnt_lo) begin
         cnt_lo_ff <= sfr_req.wdata;
      end else if (ctrl_ff.split_counter_mode & lo_wrap & reload_on) begin
         cnt_lo_ff <= rl_lo_ff;
      end else if (~ctrl_ff.split_counter_mode & hi_wrap & reload_on) begin
         cnt_lo_ff <= rl_lo_ff;
      end else if (lo_inc) begin
         cnt_lo_ff <= cnt_lo_ff + 8'h01;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cnt_hi_ff <= TM3_BYTE_RESET;
      end else if (wr_cnt_hi) begin
         cnt_hi_ff <= sfr_req.wdata;
      end else if (hi_wrap & reload_on) begin
         cnt_hi_ff <= rl_hi_ff;
      end else if (hi_inc) begin
         cnt_hi_ff <= cnt_hi_ff + 8'h01;
      end
   end

   // reload pair, overwritten by capture
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rl_lo_ff <= TM3_BYTE_RESET;
         rl_hi_ff <= TM3_BYTE_RESET;
      end else if (cap_trig) begin
         rl_lo_ff <= cnt_lo_ff;
         rl_hi_ff <= cnt_hi_ff;
      end else begin
         if (wr_rl_lo) begin
            rl_lo_ff <= sfr_req.wdata;
         end
         if (wr_rl_hi) begin
            rl_hi_ff <= sfr_req.wdata;
         end
      end
   end

   // control register; hardware set wins over a software clear
   tm3_ctrl_t nxt_ctrl;
   always_comb begin
      nxt_ctrl = ctrl_ff;
      if (wr_ctrl) begin
         nxt_ctrl = tm3_ctrl_t'(sfr_req.wdata);
      end
      if (hi_wrap | cap_trig) begin
         nxt_ctrl.high_byte_overflow_flag = 1'b1;
      end
      if (lo_wrap) begin
         nxt_ctrl.low_byte_overflow_flag = 1'b1;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ctrl_ff <= tm3_ctrl_t'(TM3_CTRL_RESET);
      end else begin
         ctrl_ff <= nxt_ctrl;
      end
   end

   // interrupt request
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= timer_irq_enable & (ctrl_ff.high_byte_overflow_flag |
            (ctrl_ff.low_byte_irq_enable &
             ctrl_ff.low_byte_overflow_flag));
      end
   end
   assign timer_irq = irq_ff;

   // read data, one cycle after the read strobe
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rdata_ff <= TM3_UNMAPPED;
      end else if (sfr_req.rd) begin
         case (sfr_req.addr)
            TM3_CTRL_ADDR: rdata_ff <= ctrl_ff;
            TM3_RELOAD_LO: rdata_ff <= rl_lo_ff;
            TM3_RELOAD_HI: rdata_ff <= rl_hi_ff;
            TM3_COUNT_LO:  rdata_ff <= cnt_lo_ff;
            TM3_COUNT_HI:  rdata_ff <= cnt_hi_ff;
            default:       rdata_ff <= TM3_UNMAPPED;
         endcase
      end
   end
   assign sfr_rdata = rdata_ff;

endmodule

//--- tm3_pins_model.sv
/*
 pin-side sources for the timer: oscillator and comparator.
 assumes both are free-running and unrelated to the core clock.
*/
`timescale 1ns/1ps
module tm3_pins_model (
   output logic ext_osc_in,
   output logic comparator_in
);
   // oscillator, period 42 ns
   initial begin
      ext_osc_in = 1'b0;
      forever #21 ext_osc_in = ~ext_osc_in;
   end
   // comparator, period 162 ns
   initial begin
      comparator_in = 1'b0;
      forever #81 comparator_in = ~comparator_in;
   end
endmodule

//--- tm3_timer_properties.sv
/*
 port checker for the timer block.
 assumes it is bound to every tm3_timer instance.
*/
`timescale 1ns/1ps
module tm3_props
   import tm3_pkg::*;
(
   input wire logic         clk,
   input wire logic         reset,
   input wire tm3_sfr_req_t sfr_req,
   input wire logic [7:0]   sfr_rdata,
   input wire logic         timer_irq_enable,
   input wire logic         timer_irq
);
   logic ctrl_wr;
   logic unm_rd;
   assign ctrl_wr = sfr_req.wr && sfr_req.addr == TM3_CTRL_ADDR;
   assign unm_rd  = sfr_req.rd && (sfr_req.addr < TM3_CTRL_ADDR ||
                                   sfr_req.addr > TM3_COUNT_HI);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   a_reset_quiet: assert property (disable iff (1'b0)
      reset && $past(reset) |-> !timer_irq && sfr_rdata == 8'h00)
      else $error("outputs not cleared in reset");
   a_irq_needs_en: assert property (
      timer_irq |-> $past(timer_irq_enable))
      else $error("irq without enable");
   a_irq_persists: assert property (
      timer_irq && timer_irq_enable && !$past(ctrl_wr) |=> timer_irq)
      else $error("irq dropped without a flag write");
   a_write_sets: assert property (
      (ctrl_wr && sfr_req.wdata[7]) ##1 timer_irq_enable |=> timer_irq)
      else $error("flag write of one gave no irq");
   a_clear_drops: assert property (
      ctrl_wr && sfr_req.wdata == 8'h00 |=> ##1 !timer_irq)
      else $error("irq stayed after clearing flags");
   a_unmapped_zero: assert property (
      unm_rd |=> sfr_rdata == TM3_UNMAPPED)
      else $error("unmapped read not zero");
   a_rdata_holds: assert property (
      !sfr_req.rd |=> $stable(sfr_rdata))
      else $error("read data moved without a read");
   a_irq_off_dis: assert property (
      !timer_irq_enable ##1 !timer_irq_enable |-> !timer_irq)
      else $error("irq while disabled");
endmodule
bind tm3_timer tm3_props u_props (.clk(clk), .reset(reset),
   .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
   .timer_irq_enable(timer_irq_enable), .timer_irq(timer_irq));

//--- tb_top.sv
/*
 testbench for the timer block over its register bus.
 assumes the pin model supplies oscillator and comparator.
*/
`timescale 1ns/1ps
module tb_top
   import tm3_pkg::*;
;
   logic         clk    = 1'b0;
   logic         reset  = 1'b1;
   logic         lsel   = 1'b0;
   logic         usel   = 1'b0;
   logic         irq_en = 1'b0;
   tm3_sfr_req_t req    = '0;
   logic [7:0]   rdata;
   logic         irq;
   logic         comp;
   logic         osc;
   int           mismatches  = 0;
   int           check_count = 0;
   logic [7:0]   lo_tab [4]  = '{8'h0f, 8'h01, 8'h00, 8'h04};
   logic [7:0]   hi_tab [4]  = '{8'h12, 8'h03, 8'h00, 8'h06};
   logic [7:0]   cap_ctl [2] = '{8'h15, 8'h14};
   logic [7:0]   cap_lo [2]  = '{8'd83, 8'd40};
   logic [7:0]   cap_hi [2]  = '{8'd85, 8'd41};
   always #2 clk = ~clk;
   tm3_pins_model pins (.ext_osc_in(osc), .comparator_in(comp));
   tm3_timer dut (.clk(clk), .reset(reset), .sfr_req(req),
      .sfr_rdata(rdata), .upper_byte_clock_select(usel),
      .lower_byte_clock_select(lsel), .timer_irq_enable(irq_en),
      .comparator_in(comp), .ext_osc_in(osc), .timer_irq(irq));
   task automatic conclude();
      $display("mismatches %0d checks %0d", mismatches, check_count);
      if (mismatches == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(logic [7:0] g, logic [7:0] lo, logic [7:0] hi);
      check_count++;
      if ((g >= lo && g <= hi) !== 1'b1) begin
         mismatches++;
         $display("wrong value at %0t: got %h want %h..%h", $time, g, lo,
                  hi);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge clk) req <= '{1'b1, 1'b0, a, d};
      @(posedge clk) req <= '0;
   endtask
   task automatic rdv(logic [7:0] a, output logic [7:0] v);
      @(posedge clk) req <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge clk) req <= '0;
      #1 v = rdata;
   endtask
   task automatic rd(logic [7:0] a, logic [7:0] lo, logic [7:0] hi);
      logic [7:0] v;
      rdv(a, v);
      chk(v, lo, hi);
   endtask
   task automatic wait_irq();
      for (int i = 0; i < 300 && irq !== 1'b1; i++) @(posedge clk);
   endtask
   initial begin
      #40000 mismatches++;
      conclude();
   end
   initial begin
      logic [7:0] v1, v2;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      for (int a = 'h90; a < 'h97; a++) rd(8'(a), 8'h00, 8'h00);
      @(posedge clk) begin
         lsel   <= 1'b1;
         irq_en <= 1'b1;
      end
      wr(TM3_CTRL_ADDR, 8'h80);
      rd(TM3_CTRL_ADDR, 8'h80, 8'h80);
      chk({7'h00, irq}, 8'h01, 8'h01);
      @(posedge clk) irq_en <= 1'b0;
      repeat (2) @(posedge clk);
      #1 chk({7'h00, irq}, 8'h00, 8'h00);
      @(posedge clk) irq_en <= 1'b1;
      wr(TM3_CTRL_ADDR, 8'h60);
      rd(TM3_CTRL_ADDR, 8'h60, 8'h60);
      chk({7'h00, irq}, 8'h01, 8'h01);
      wr(TM3_CTRL_ADDR, 8'h00);
      rd(TM3_CTRL_ADDR, 8'h00, 8'h00);
      chk({7'h00, irq}, 8'h00, 8'h00);
      wr(TM3_RELOAD_LO, 8'h34);
      wr(TM3_RELOAD_HI, 8'h12);
      wr(TM3_COUNT_LO, 8'hff);
      wr(TM3_COUNT_HI, 8'hff);
      wr(TM3_CTRL_ADDR, 8'h04);
      rd(TM3_CTRL_ADDR, 8'hc4, 8'hc4);
      rd(TM3_COUNT_HI, 8'h12, 8'h12);
      chk({7'h00, irq}, 8'h01, 8'h01);
      wr(TM3_CTRL_ADDR, 8'h00);
      rd(TM3_CTRL_ADDR, 8'h00, 8'h00);
      wr(TM3_COUNT_LO, 8'hff);
      wr(TM3_COUNT_HI, 8'h00);
      wr(TM3_RELOAD_LO, 8'h55);
      wr(TM3_CTRL_ADDR, 8'h28);
      rd(TM3_CTRL_ADDR, 8'h68, 8'h68);
      rd(TM3_COUNT_HI, 8'h00, 8'h00);
      rd(TM3_COUNT_LO, 8'h55, 8'h5f);
      chk({7'h00, irq}, 8'h01, 8'h01);
      @(posedge clk) lsel <= 1'b0;
      for (int c = 0; c < 4; c++) begin
         wr(TM3_CTRL_ADDR, 8'h00);
         wr(TM3_COUNT_LO, 8'h00);
         wr(TM3_CTRL_ADDR, 8'h04 | 8'(c));
         repeat (200) @(posedge clk);
         wr(TM3_CTRL_ADDR, 8'h00);
         rd(TM3_COUNT_LO, lo_tab[c], hi_tab[c]);
      end
      @(posedge clk) usel <= 1'b1;
      wr(TM3_COUNT_LO, 8'h10);
      wr(TM3_RELOAD_HI, 8'hf0);
      wr(TM3_COUNT_HI, 8'hff);
      wr(TM3_CTRL_ADDR, 8'h0e);
      rd(TM3_CTRL_ADDR, 8'h8e, 8'h8e);
      chk({7'h00, irq}, 8'h01, 8'h01);
      rd(TM3_COUNT_HI, 8'hf0, 8'hfe);
      wr(TM3_CTRL_ADDR, 8'h0a);
      rdv(TM3_COUNT_HI, v1);
      rd(TM3_COUNT_HI, v1, v1);
      rd(TM3_COUNT_LO, 8'h10, 8'h10);
      @(posedge clk) lsel <= 1'b1;
      wr(TM3_RELOAD_HI, 8'haa);
      for (int m = 0; m < 2; m++) begin
         wr(TM3_CTRL_ADDR, 8'h00);
         wr(TM3_COUNT_LO, 8'h00);
         wr(TM3_COUNT_HI, 8'h00);
         wr(TM3_CTRL_ADDR, cap_ctl[m]);
         wait_irq();
         rd(TM3_CTRL_ADDR, cap_ctl[m] | 8'h80, cap_ctl[m] | 8'h80);
         rd(TM3_RELOAD_HI, 8'h00, 8'h00);
         rdv(TM3_RELOAD_LO, v1);
         wr(TM3_CTRL_ADDR, cap_ctl[m]);
         repeat (2) @(posedge clk);
         wait_irq();
         rdv(TM3_RELOAD_LO, v2);
         chk(v2 - v1, cap_lo[m], cap_hi[m]);
      end
      @(posedge clk) reset <= 1'b1;
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      rd(TM3_CTRL_ADDR, 8'h00, 8'h00);
      rd(TM3_RELOAD_LO, 8'h00, 8'h00);
      chk({7'h00, irq}, 8'h00, 8'h00);
      conclude();
   end
endmodule
